// [adcss_pkg.sv]
// Shared constants, register map and state types of the startup sequencer
package adcss_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int CONV_RESET_NS  = 100;
	localparam int CONV_RESET_CYC = (CONV_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_HOLD_NS   = 50;
	localparam int SYNC_HOLD_CYC  = (SYNC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LINK_INIT_NS   = 200;
	localparam int LINK_INIT_CYC  = (LINK_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAL_RUN_NS     = 1000;
	localparam int CAL_RUN_CYC    = (CAL_RUN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W          = 8;

	// ==========================================================
	// Converter configuration port
	localparam int CFG_AW = 3;
	localparam int CFG_DW = 8;
	localparam int MODE_W = 2;
	localparam int THR_W  = 7;
	localparam logic [CFG_AW-1:0] DREG_LINK_EN  = 3'h0;
	localparam logic [CFG_AW-1:0] DREG_CAL_EN   = 3'h1;
	localparam logic [CFG_AW-1:0] DREG_OUT_MODE = 3'h2;
	localparam logic [CFG_AW-1:0] DREG_SYNC_SEL = 3'h3;
	localparam logic [CFG_AW-1:0] DREG_CAL_OPT  = 3'h4;
	localparam logic [CFG_AW-1:0] DREG_OVR      = 3'h5;
	localparam logic [CFG_AW-1:0] DREG_CAL_TRIG = 3'h6;
	localparam int DCAL_BG_BIT  = 0;
	localparam int DCAL_OFS_BIT = 1;
	localparam int DOVR_EN_BIT  = 0;
	localparam int DOVR_THR_LSB = 1;

	// ==========================================================
	// Host APB registers
	localparam int APB_AW = 4;
	localparam logic [APB_AW-1:0] A_CTRL   = 4'h0;
	localparam logic [APB_AW-1:0] A_CFG    = 4'h4;
	localparam logic [APB_AW-1:0] A_STATUS = 4'h8;
	localparam int CTRL_START_BIT = 0;
	localparam int CFG_MODE_LSB   = 0;
	localparam int CFG_SYNC_SEL   = 2;
	localparam int CFG_CAL_BG     = 3;
	localparam int CFG_CAL_OFS    = 4;
	localparam int CFG_OVERRANGE_DETECT_ENABLE     = 5;
	localparam int CFG_SYNC_REQ   = 6;
	localparam int CFG_SYSREF_EN  = 7;
	localparam int CFG_THR_LSB    = 8;
	localparam int CFG_W          = 15;
	localparam logic [CFG_W-1:0] CFG_RESET = 15'h0000;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_LINK_BIT = 2;
	localparam int ST_CAL_BIT  = 3;
	localparam int ST_STEP_LSB = 4;

	// ==========================================================
	// State types
	typedef enum logic [1:0] {
		LNK_HALT = 2'h0,
		LNK_INIT = 2'h1,
		LNK_RUN  = 2'h3
	} adcss_link_st_t;

	typedef enum logic [1:0] {
		CAL_HALT = 2'h0,
		CAL_IDLE = 2'h1,
		CAL_RUN  = 2'h3
	} adcss_cal_st_t;

	typedef enum logic [3:0] {
		SQ_IDLE     = 4'h0,
		SQ_RESET    = 4'h1,
		SQ_WAIT_CLK = 4'h3,
		SQ_LINK_OFF = 4'h2,
		SQ_CAL_OFF  = 4'h6,
		SQ_MODE     = 4'h7,
		SQ_SYNC_SEL = 4'h5,
		SQ_CAL_OPT  = 4'h4,
		SQ_CAL_ON   = 4'hC,
		SQ_OVR      = 4'hD,
		SQ_LINK_ON  = 4'hF,
		SQ_SYNC     = 4'hE,
		SQ_TRIG0    = 4'hA,
		SQ_TRIG1    = 4'hB,
		SQ_DONE     = 4'h9
	} adcss_seq_st_t;
endpackage

// [adcss_link_if.sv]
// Connection between the sequencing controller and the converter end
`timescale 1ns/1ps
`default_nettype none
interface adcss_link_if;
	// Configuration writes
	logic                          cfg_valid;
	logic [adcss_pkg::CFG_AW-1:0] cfg_addr;
	logic [adcss_pkg::CFG_DW-1:0] cfg_data;
	logic                          cfg_ready;
	// Reset and alignment
	logic                          conv_reset_n;
	logic                          sysref;
	// Sync request lines
	logic                          single_ended_sync_input;
	logic                          differential_timestamp_input_p;
	logic                          differential_timestamp_input_n;
	// Converter state seen by the controller
	logic                          link_running;
	logic                          cal_busy;

	modport dev (
		input  cfg_valid, cfg_addr, cfg_data, conv_reset_n, sysref,
		input  single_ended_sync_input,
		input  differential_timestamp_input_p, differential_timestamp_input_n,
		output cfg_ready, link_running, cal_busy
	);
	modport host (
		output cfg_valid, cfg_addr, cfg_data, conv_reset_n, sysref,
		output single_ended_sync_input,
		output differential_timestamp_input_p, differential_timestamp_input_n,
		input  cfg_ready, link_running, cal_busy
	);
endinterface
`default_nettype wire

// [adcss_rise.sv]
// Rising edge detector for single-bit levels
`timescale 1ns/1ps
`default_nettype none
module adcss_rise (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Level in, pulse out
	input  wire logic level,
	output logic      rise
);
	logic prev_r;

	// Previous level; starts low so a level high at reset reads as an edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= level;
		end
	end

	assign rise = level & ~prev_r;
endmodule // adcss_rise
`default_nettype wire

// [adcss_device.sv]
// Converter end: configuration registers, link and calibration state machines
`timescale 1ns/1ps
`default_nettype none
module adcss_device #(
	parameter int LINK_INIT = adcss_pkg::LINK_INIT_CYC,
	parameter int CAL_RUN   = adcss_pkg::CAL_RUN_CYC
) (
	// Clock and reset
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	// Controller side
	adcss_link_if.dev                         lnk,
	// User side
	output logic [adcss_pkg::MODE_W-1:0]      output_mode_select,
	output logic                              cal_background,
	output logic                              cal_offset,
	output logic                              overrange_detect_enable,
	output logic [adcss_pkg::THR_W-1:0]       overrange_threshold,
	output logic                              strobe_out,
	output logic                              cal_done,
	output logic                              aligned
);
	adcss_pkg::adcss_link_st_t lst_r;
	adcss_pkg::adcss_cal_st_t  cst_r;
	logic                            link_en_r, cal_en_r, sync_sel_r, trig_r;
	logic [adcss_pkg::MODE_W-1:0]    mode_r;
	logic                            cal_bg_r, cal_ofs_r, overrange_detect_enable_r;
	logic [adcss_pkg::THR_W-1:0]     thr_r;
	logic [adcss_pkg::CNT_W-1:0]     lcnt_r, ccnt_r;
	logic                            strobe_r, done_r, aligned_r, ready_r;
	logic                            wr, soft_rst, sel_sync, sync_rise, trig_rise;
	logic                            sync_live;

	// ==========================================================
	// Write decode; mode, sync select and calibration options refused while their enable is set
	assign wr       = lnk.cfg_valid & ready_r;
	assign soft_rst = ~lnk.conv_reset_n;
	assign sel_sync = sync_sel_r ? (lnk.differential_timestamp_input_p &
	                                 ~lnk.differential_timestamp_input_n)
	                             : lnk.single_ended_sync_input;

	// Configuration registers; a held reset from the controller clears them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{link_en_r, cal_en_r, sync_sel_r, trig_r} <= 4'h0;
			{mode_r, cal_bg_r, cal_ofs_r, overrange_detect_enable_r, thr_r} <= 12'h000;
			ready_r <= 1'b0;
		end else if (soft_rst) begin
			{link_en_r, cal_en_r, sync_sel_r, trig_r} <= 4'h0;
			{mode_r, cal_bg_r, cal_ofs_r, overrange_detect_enable_r, thr_r} <= 12'h000;
			ready_r <= 1'b0;
		end else begin
			ready_r <= 1'b1;
			if (wr) begin
				unique case (lnk.cfg_addr)
					adcss_pkg::DREG_LINK_EN:  link_en_r <= lnk.cfg_data[0];
					adcss_pkg::DREG_CAL_EN:   cal_en_r  <= lnk.cfg_data[0];
					adcss_pkg::DREG_OUT_MODE: if (!link_en_r) begin
						mode_r <= lnk.cfg_data[adcss_pkg::MODE_W-1:0];
					end
					adcss_pkg::DREG_SYNC_SEL: if (!link_en_r) begin
						sync_sel_r <= lnk.cfg_data[0];
					end
					adcss_pkg::DREG_CAL_OPT:  if (!cal_en_r) begin
						cal_bg_r  <= lnk.cfg_data[adcss_pkg::DCAL_BG_BIT];
						cal_ofs_r <= lnk.cfg_data[adcss_pkg::DCAL_OFS_BIT];
					end
					adcss_pkg::DREG_OVR: begin
						overrange_detect_enable_r <= lnk.cfg_data[adcss_pkg::DOVR_EN_BIT];
						thr_r    <= lnk.cfg_data[adcss_pkg::DOVR_THR_LSB +: adcss_pkg::THR_W];
					end
					adcss_pkg::DREG_CAL_TRIG: trig_r <= lnk.cfg_data[0];
					default: ;
				endcase
			end
		end
	end

	// Sync only counts while running, so a sync held through link init still strobes
	assign sync_live = sel_sync & (lst_r == adcss_pkg::LNK_RUN);
	adcss_rise u_sync_rise (.pclk(pclk), .presetn(presetn), .level(sync_live), .rise(sync_rise));
	adcss_rise u_trig_rise (.pclk(pclk), .presetn(presetn), .level(trig_r), .rise(trig_rise));

	// ==========================================================
	// Output link: halted while disabled, short init, then running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lst_r  <= adcss_pkg::LNK_HALT;
			lcnt_r <= '0;
		end else if (!link_en_r) begin
			lst_r  <= adcss_pkg::LNK_HALT;
			lcnt_r <= '0;
		end else begin
			unique case (lst_r)
				adcss_pkg::LNK_HALT: lst_r <= adcss_pkg::LNK_INIT;
				adcss_pkg::LNK_INIT: begin
					lcnt_r <= lcnt_r + 1'b1;
					if (lcnt_r == adcss_pkg::CNT_W'(LINK_INIT - 1)) begin
						lst_r <= adcss_pkg::LNK_RUN;
					end
				end
				adcss_pkg::LNK_RUN:  lst_r <= adcss_pkg::LNK_RUN;
				default:             lst_r <= adcss_pkg::LNK_HALT;
			endcase
		end
	end

	// ==========================================================
	// Calibration: a trigger edge only starts a run while enabled and idle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cst_r  <= adcss_pkg::CAL_HALT;
			ccnt_r <= '0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (!cal_en_r) begin
				cst_r  <= adcss_pkg::CAL_HALT;
				ccnt_r <= '0;
			end else begin
				unique case (cst_r)
					adcss_pkg::CAL_HALT: cst_r <= adcss_pkg::CAL_IDLE;
					adcss_pkg::CAL_IDLE: if (trig_rise) begin
						cst_r <= adcss_pkg::CAL_RUN;
					end
					adcss_pkg::CAL_RUN: begin
						ccnt_r <= ccnt_r + 1'b1;
						if (ccnt_r == adcss_pkg::CNT_W'(CAL_RUN - 1)) begin
							cst_r  <= adcss_pkg::CAL_IDLE;
							ccnt_r <= '0;
							done_r <= 1'b1;
						end
					end
					default: cst_r <= adcss_pkg::CAL_HALT;
				endcase
			end
		end
	end

	// ==========================================================
	// Strobe on sync edge while running; alignment flag on reference pulse
	// The reference pulse follows the enable at once, so it is taken while the link still reads halted, before init
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_r  <= 1'b0;
			aligned_r <= 1'b0;
		end else begin
			strobe_r <= sync_rise & (lst_r == adcss_pkg::LNK_RUN);
			if (!link_en_r) begin
				aligned_r <= 1'b0;
			end else if (lnk.sysref) begin
				aligned_r <= 1'b1;
			end
		end
	end

	assign lnk.cfg_ready            = ready_r;
	assign lnk.link_running         = (lst_r == adcss_pkg::LNK_RUN);
	assign lnk.cal_busy             = (cst_r == adcss_pkg::CAL_RUN);
	assign output_mode_select       = mode_r;
	assign cal_background           = cal_bg_r;
	assign cal_offset               = cal_ofs_r;
	assign overrange_detect_enable  = overrange_detect_enable_r;
	assign overrange_threshold      = thr_r;
	assign strobe_out               = strobe_r;
	assign cal_done                 = done_r;
	assign aligned                  = aligned_r;
endmodule // adcss_device
`default_nettype wire

// [adcss_host.sv]
// Controller end: APB-programmed startup sequencer driving the converter
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Start only after a converter reset
// - Wait for a stable sampling clock
// - Halt output link before link settings
// - Halt calibration after link halt
// - Program output mode while both halted
// - Choose sync source, single or differential
// - Set calibration mode and offset option
// - Re-enable calibration after its options
// - Optionally set overrange before link enable
// - Enable output link, receiver then initialises
// - Pulse selected sync only when requested
// - Write trigger zero then one last
// - Supply reference pulse for deterministic alignment
module adcss_host #(
	parameter int RESET_HOLD = adcss_pkg::CONV_RESET_CYC,
	parameter int SYNC_HOLD  = adcss_pkg::SYNC_HOLD_CYC
) (
	// Clock and reset
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// APB slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [adcss_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Clock source status
	input  wire logic                          clk_stable,
	// Converter side
	adcss_link_if.host                         lnk
);
	adcss_pkg::adcss_seq_st_t       st_r, st_nxt;
	logic [adcss_pkg::CFG_W-1:0]    cfg_r;
	logic [adcss_pkg::CNT_W-1:0]    cnt_r;
	logic [31:0]                    prdata_r;
	logic                           pready_r, pslverr_r;
	logic                           valid_r, valid_nxt;
	logic [adcss_pkg::CFG_AW-1:0]   addr_r, addr_nxt;
	logic [adcss_pkg::CFG_DW-1:0]   data_r, data_nxt;
	logic                           rst_n_r, sysref_r, se_sync_r, ts_r;
	logic                           acc, wr_acc, hit_ctrl, hit_cfg, hit_stat, mapped;
	logic                           busy, start, accepted, cnt_end_rst, cnt_end_sync;
	logic [31:0]                    rd_mux;

	// ==========================================================
	// APB decode; answer comes one cycle into the access phase
	assign acc      = psel & penable & ~pready_r;
	assign hit_ctrl = (paddr == adcss_pkg::A_CTRL);
	assign hit_cfg  = (paddr == adcss_pkg::A_CFG);
	assign hit_stat = (paddr == adcss_pkg::A_STATUS);
	assign mapped   = hit_ctrl | hit_cfg | hit_stat;
	assign wr_acc   = acc & pwrite & mapped;
	assign busy     = (st_r != adcss_pkg::SQ_IDLE) & (st_r != adcss_pkg::SQ_DONE);
	// A restart is refused while a sequence is in flight
	assign start    = wr_acc & hit_ctrl & pwdata[adcss_pkg::CTRL_START_BIT] & ~busy;
	assign rd_mux   = hit_cfg  ? {17'h00000, cfg_r} :
	                  hit_stat ? {24'h000000, st_r, lnk.cal_busy, lnk.link_running,
	                              (st_r == adcss_pkg::SQ_DONE), busy} :
	                             32'h00000000;

	// Bus answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h00000000;
		end else begin
			pready_r  <= acc;
			pslverr_r <= acc & ~mapped;
			if (acc & ~pwrite) begin
				prdata_r <= rd_mux;
			end
		end
	end

	// Settings; changes while busy would race the writes, so they are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= adcss_pkg::CFG_RESET;
		end else if (wr_acc & hit_cfg & ~busy) begin
			cfg_r <= pwdata[adcss_pkg::CFG_W-1:0];
		end
	end

	// ==========================================================
	// Sequencer: each write step holds valid until the converter takes it
	assign accepted     = valid_r & lnk.cfg_ready;
	assign cnt_end_rst  = (cnt_r == adcss_pkg::CNT_W'(RESET_HOLD - 1));
	assign cnt_end_sync = (cnt_r == adcss_pkg::CNT_W'(SYNC_HOLD - 1));

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			adcss_pkg::SQ_IDLE:     if (start) st_nxt = adcss_pkg::SQ_RESET;
			adcss_pkg::SQ_DONE:     if (start) st_nxt = adcss_pkg::SQ_RESET;
			adcss_pkg::SQ_RESET:    if (cnt_end_rst) st_nxt = adcss_pkg::SQ_WAIT_CLK;
			adcss_pkg::SQ_WAIT_CLK: if (clk_stable) st_nxt = adcss_pkg::SQ_LINK_OFF;
			adcss_pkg::SQ_LINK_OFF: if (accepted) st_nxt = adcss_pkg::SQ_CAL_OFF;
			adcss_pkg::SQ_CAL_OFF:  if (accepted) st_nxt = adcss_pkg::SQ_MODE;
			adcss_pkg::SQ_MODE:     if (accepted) st_nxt = adcss_pkg::SQ_SYNC_SEL;
			adcss_pkg::SQ_SYNC_SEL: if (accepted) st_nxt = adcss_pkg::SQ_CAL_OPT;
			adcss_pkg::SQ_CAL_OPT:  if (accepted) st_nxt = adcss_pkg::SQ_CAL_ON;
			adcss_pkg::SQ_CAL_ON:   if (accepted) st_nxt = adcss_pkg::SQ_OVR;
			adcss_pkg::SQ_OVR:      if (accepted) st_nxt = adcss_pkg::SQ_LINK_ON;
			adcss_pkg::SQ_LINK_ON:  if (accepted) begin
				st_nxt = cfg_r[adcss_pkg::CFG_SYNC_REQ] ? adcss_pkg::SQ_SYNC
				                                         : adcss_pkg::SQ_TRIG0;
			end
			adcss_pkg::SQ_SYNC:     if (cnt_end_sync) st_nxt = adcss_pkg::SQ_TRIG0;
			adcss_pkg::SQ_TRIG0:    if (accepted) st_nxt = adcss_pkg::SQ_TRIG1;
			adcss_pkg::SQ_TRIG1:    if (accepted) st_nxt = adcss_pkg::SQ_DONE;
			default:                st_nxt = adcss_pkg::SQ_IDLE;
		endcase
	end

	// Write contents for the state being entered
	always_comb begin
		valid_nxt = 1'b1;
		addr_nxt  = adcss_pkg::DREG_LINK_EN;
		data_nxt  = 8'h00;
		unique case (st_nxt)
			adcss_pkg::SQ_LINK_OFF: addr_nxt = adcss_pkg::DREG_LINK_EN;
			adcss_pkg::SQ_CAL_OFF:  addr_nxt = adcss_pkg::DREG_CAL_EN;
			adcss_pkg::SQ_MODE: begin
				addr_nxt = adcss_pkg::DREG_OUT_MODE;
				data_nxt = {6'h00, cfg_r[adcss_pkg::CFG_MODE_LSB +: adcss_pkg::MODE_W]};
			end
			adcss_pkg::SQ_SYNC_SEL: begin
				addr_nxt = adcss_pkg::DREG_SYNC_SEL;
				data_nxt = {7'h00, cfg_r[adcss_pkg::CFG_SYNC_SEL]};
			end
			adcss_pkg::SQ_CAL_OPT: begin
				addr_nxt = adcss_pkg::DREG_CAL_OPT;
				data_nxt = {6'h00, cfg_r[adcss_pkg::CFG_CAL_OFS], cfg_r[adcss_pkg::CFG_CAL_BG]};
			end
			adcss_pkg::SQ_CAL_ON: begin
				addr_nxt = adcss_pkg::DREG_CAL_EN;
				data_nxt = 8'h01;
			end
			adcss_pkg::SQ_OVR: begin
				addr_nxt = adcss_pkg::DREG_OVR;
				data_nxt = {cfg_r[adcss_pkg::CFG_THR_LSB +: adcss_pkg::THR_W],
				            cfg_r[adcss_pkg::CFG_OVERRANGE_DETECT_ENABLE]};
			end
			adcss_pkg::SQ_LINK_ON: begin
				addr_nxt = adcss_pkg::DREG_LINK_EN;
				data_nxt = 8'h01;
			end
			adcss_pkg::SQ_TRIG0:    addr_nxt = adcss_pkg::DREG_CAL_TRIG;
			adcss_pkg::SQ_TRIG1: begin
				addr_nxt = adcss_pkg::DREG_CAL_TRIG;
				data_nxt = 8'h01;
			end
			default:                valid_nxt = 1'b0;
		endcase
	end

	// State, write request and step counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r    <= adcss_pkg::SQ_IDLE;
			valid_r <= 1'b0;
			addr_r  <= adcss_pkg::DREG_LINK_EN;
			data_r  <= 8'h00;
			cnt_r   <= '0;
		end else begin
			st_r    <= st_nxt;
			valid_r <= valid_nxt;
			addr_r  <= addr_nxt;
			data_r  <= data_nxt;
			cnt_r   <= (st_nxt == st_r) ? cnt_r + 1'b1 : '0;
		end
	end

	// ==========================================================
	// Pin drive: converter reset, sync lines and reference pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_n_r   <= 1'b0;
			sysref_r  <= 1'b0;
			se_sync_r <= 1'b0;
			ts_r      <= 1'b0;
		end else begin
			rst_n_r   <= (st_nxt != adcss_pkg::SQ_RESET);
			sysref_r  <= accepted & (st_r == adcss_pkg::SQ_LINK_ON)
			             & cfg_r[adcss_pkg::CFG_SYSREF_EN];
			se_sync_r <= (st_nxt == adcss_pkg::SQ_SYNC) & ~cfg_r[adcss_pkg::CFG_SYNC_SEL];
			ts_r      <= (st_nxt == adcss_pkg::SQ_SYNC) & cfg_r[adcss_pkg::CFG_SYNC_SEL];
		end
	end

	assign prdata                             = prdata_r;
	assign pready                             = pready_r;
	assign pslverr                            = pslverr_r;
	assign lnk.cfg_valid                      = valid_r;
	assign lnk.cfg_addr                       = addr_r;
	assign lnk.cfg_data                       = data_r;
	assign lnk.conv_reset_n                   = rst_n_r;
	assign lnk.sysref                         = sysref_r;
	assign lnk.single_ended_sync_input        = se_sync_r;
	assign lnk.differential_timestamp_input_p = ts_r;
	assign lnk.differential_timestamp_input_n = ~ts_r;
endmodule // adcss_host
`default_nettype wire

// [adcss_assertions.sv]
// Link checks between the controller end and the converter end
`timescale 1ns/1ps
`default_nettype none
module adcss_assertions (
	// Clock and reset
	input wire logic                         pclk,
	input wire logic                         presetn,
	// Link signals
	input wire logic                         cfg_valid,
	input wire logic [adcss_pkg::CFG_AW-1:0] cfg_addr,
	input wire logic [adcss_pkg::CFG_DW-1:0] cfg_data,
	input wire logic                         cfg_ready,
	input wire logic                         conv_reset_n,
	input wire logic                         sysref,
	input wire logic                         single_ended_sync_input,
	input wire logic                         differential_timestamp_input_p,
	input wire logic                         differential_timestamp_input_n,
	input wire logic                         link_running,
	input wire logic                         cal_busy
);
	// ==========================================================
	// Write decode; bit 0 carries every enable and trigger value
	wire tk    = cfg_valid && cfg_ready;
	wire d0    = cfg_data[0];
	wire w_lk  = tk && cfg_addr == adcss_pkg::DREG_LINK_EN;
	wire w_ce  = tk && cfg_addr == adcss_pkg::DREG_CAL_EN;
	wire w_tr  = tk && cfg_addr == adcss_pkg::DREG_CAL_TRIG;
	wire w_st  = tk && (cfg_addr == adcss_pkg::DREG_OUT_MODE
		|| cfg_addr == adcss_pkg::DREG_SYNC_SEL || cfg_addr == adcss_pkg::DREG_CAL_OPT);
	wire lk_on = w_lk && d0;
	wire tr0   = w_tr && !d0;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==========================================================
	// Ordering and state machine response
	AST_LINK_HALT: assert property (w_lk && !d0 |=> ##1 !link_running)
		else $error("link running after halt write");
	AST_CAL_NEXT: assert property (w_lk && !d0
		|=> cfg_valid && cfg_addr == adcss_pkg::DREG_CAL_EN && !d0)
		else $error("calibration halt does not follow link halt");
	AST_CAL_HALT: assert property (w_ce && !d0 |=> ##1 !cal_busy)
		else $error("calibration busy after halt write");
	AST_SET_HALTED: assert property (w_st |-> !link_running && !cal_busy)
		else $error("setting written while a machine runs");
	AST_CAL_ON: assert property (w_ce && d0
		|-> $past(cfg_addr) == adcss_pkg::DREG_CAL_OPT)
		else $error("calibration enabled before its options");
	AST_LINK_UP: assert property (lk_on |=> !link_running ##[1:10] link_running)
		else $error("link did not start");
	AST_SYSREF: assert property (sysref |-> $past(lk_on) || $past(lk_on, 2))
		else $error("reference pulse not after link enable");
	AST_TS_PAIR: assert property (differential_timestamp_input_p != differential_timestamp_input_n)
		else $error("timestamp pair not complementary");
	AST_TRIG_ORDER: assert property (w_tr && d0 |-> $past(tr0))
		else $error("trigger one not preceded by trigger zero");
	AST_RST_QUIET: assert property (!conv_reset_n |-> !tk)
		else $error("write taken during converter reset");

	// Main scenarios
	cover property (w_tr && d0 ##[1:3] cal_busy);
	cover property (sysref);
	cover property (w_st && cfg_addr == adcss_pkg::DREG_SYNC_SEL && d0);
endmodule // adcss_assertions
`default_nettype wire

// [test_adc_startup_sequencer.sv]
// Self-checking bench: controller and converter ends joined by the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module test_adc_startup_sequencer;
	// ==========================================================
	// Signals
	logic        pclk, presetn, psel, penable, pwrite, clk_stable;
	logic [3:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, bg, ofs, ovr, strobe, cal_done, aligned;
	logic [1:0]  mode;
	logic [6:0]  thr;
	int          err_total, samples_checked, nwr, nse, nts, nsr, ncd, nst;
	adcss_link_if lnk ();

	// Short counts keep the run brief; expectations use the same figures
	adcss_host #(.RESET_HOLD(2), .SYNC_HOLD(5)) adcss_host_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .clk_stable(clk_stable), .lnk(lnk));
	adcss_device #(.LINK_INIT(2), .CAL_RUN(8)) adcss_device_i (.pclk(pclk), .presetn(presetn),
		.lnk(lnk), .output_mode_select(mode), .cal_background(bg), .cal_offset(ofs),
		.overrange_detect_enable(ovr), .overrange_threshold(thr), .strobe_out(strobe),
		.cal_done(cal_done), .aligned(aligned));
	adcss_assertions adcss_assertions_i (.pclk(pclk), .presetn(presetn),
		.cfg_valid(lnk.cfg_valid), .cfg_addr(lnk.cfg_addr), .cfg_data(lnk.cfg_data),
		.cfg_ready(lnk.cfg_ready), .conv_reset_n(lnk.conv_reset_n), .sysref(lnk.sysref),
		.single_ended_sync_input(lnk.single_ended_sync_input),
		.differential_timestamp_input_p(lnk.differential_timestamp_input_p),
		.differential_timestamp_input_n(lnk.differential_timestamp_input_n),
		.link_running(lnk.link_running), .cal_busy(lnk.cal_busy));

	// Clock
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end

	// Wire activity counters; scenarios read them at falling edges to avoid races
	always @(posedge pclk) begin
		nwr += lnk.cfg_valid && lnk.cfg_ready;
		nse += lnk.single_ended_sync_input;
		nts += lnk.differential_timestamp_input_p;
		nsr += lnk.sysref;
		ncd += cal_done;
		nst += strobe;
	end

	// ==========================================================
	// APB transfer; waits for pready, bounded so a dead slave cannot hang us
	task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		q = prdata;
		e = pslverr;
		err_total += (n >= 50);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask

	task automatic give_verdict;
		if (err_total == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Reset values, idle status and an unmapped address
	task automatic check_regs;
		logic [31:0] q;
		logic        e;
		apb(1'h0, adcss_pkg::A_CFG, 32'h0, q, e);
		`CHK("cfg reset", adcss_pkg::CFG_RESET, q[14:0])
		apb(1'h0, adcss_pkg::A_STATUS, 32'h0, q, e);
		`CHK("status idle", 2'h0, q[1:0])
		apb(1'h1, 4'hC, 32'hFFFFFFFF, q, e);
		`CHK("wr err", 1'h1, e)
		apb(1'h0, 4'hC, 32'h0, q, e);
		`CHK("rd err", {1'h1, 32'h0}, {e, q})
	endtask

	// One full startup; later runs restart from converter reset
	task automatic run_seq(input logic [14:0] c);
		logic [31:0] q;
		logic        e;
		int          b[6];
		int          n;
		apb(1'h1, adcss_pkg::A_CFG, {17'h0, c}, q, e);
		apb(1'h1, adcss_pkg::A_CTRL, 32'h1, q, e);
		apb(1'h1, adcss_pkg::A_CFG, {17'h0, ~c}, q, e);
		apb(1'h0, adcss_pkg::A_CFG, 32'h0, q, e);
		`CHK("cfg frozen", c, q[14:0])
		`CHK("cfg resp", 1'h0, e)
		@(negedge pclk);
		b = '{nwr, nse, nts, nsr, ncd, nst};
		repeat (20) @(posedge pclk);
		`CHK("early writes", 0, nwr - b[0])
		clk_stable <= 1'h1;
		n = 0;
		do begin
			apb(1'h0, adcss_pkg::A_STATUS, 32'h0, q, e);
			n++;
		end while (q[adcss_pkg::ST_DONE_BIT] !== 1'h1 && n < 100);
		`CHK("done", 1'h1, q[adcss_pkg::ST_DONE_BIT])
		`CHK("link up", 1'h1, q[adcss_pkg::ST_LINK_BIT])
		n = 0;
		while (ncd == b[4] && n < 200) begin
			@(posedge pclk);
			n++;
		end
		@(negedge pclk);
		`CHK("writes", 10, nwr - b[0])
		`CHK("sysref", c[7] ? 1 : 0, nsr - b[3])
		`CHK("sync se", (c[6] && !c[2]) ? 5 : 0, nse - b[1])
		`CHK("sync ts", (c[6] && c[2]) ? 5 : 0, nts - b[2])
		`CHK("strobe", c[6] ? 1 : 0, nst - b[5])
		`CHK("aligned", c[7], aligned)
		`CHK("cal runs", 1, ncd - b[4])
		`CHK("settings", {c[1:0], c[3], c[4], c[5], c[14:8]}, {mode, bg, ofs, ovr, thr})
		@(posedge pclk);
		clk_stable <= 1'h0;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		presetn = 1'h0;
		{psel, penable, pwrite, paddr, pwdata, clk_stable} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		check_regs();
		run_seq(15'h55E9);
		run_seq(15'h2A56);
		run_seq(15'h7FBB);
		give_verdict();
	end

	// Watchdog, about twenty times the expected run
	initial begin
		repeat (5000) @(posedge pclk);
		err_total++;
		give_verdict();
	end
endmodule // test_adc_startup_sequencer
`default_nettype wire
